// file: rtl/rtc_i2c_read_and_bus_timeout.sv
// Behaviour
// - several bytes readable in one transfer
// - master ack means drive the next byte
// - long scl low returns interface to idle
// - stall recovery releases sda
// - stall timed only while oscillator runs
// - device never holds scl low
// - interrupt pin only pulled low or released
// - sda only pulled low or released
// - answer only the fixed address, lsb direction
// - wrong address ignored until next start
// - first write byte loads register pointer
// - reads start at current register pointer
`timescale 1ns/1ps
`default_nettype none

`include "rtc_i2c_defs.svh"

module rtc_i2c_read_and_bus_timeout
	import rtc_i2c_pkg::*;
#(
	parameter int STALL_CYCLES = `STALL_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_osc_clk,
	input wire logic i_osc_en,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic i_irq_a_req,
	output logic o_refclk_in_irq_a_pin_out,
	output logic o_refclk_in_irq_a_pin_oe,
	output logic [7:0] o_reg_addr,
	input wire logic [7:0] i_reg_rdata,
	output logic o_wr_en,
	output logic [7:0] o_wr_data
);
	stall_if sif ();

	logic scl_s1_q, scl_s2_q, scl_p_q;
	logic sda_s1_q, sda_s2_q, sda_p_q;
	logic stl_s1_q, stl_s2_q, stl_s3_q;
	logic start_tgl_q;
	logic scl_rise, scl_fall, start_ev, stop_ev, stall_ev;
	slave_state_type state_q;
	logic [3:0] bit_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic rw_q, first_q, ack_q;
	logic sda_oe_q, irq_oe_q, wr_en_q;
	logic [7:0] ptr_q, wr_data_q;

	// scl is only ever read; there is no driver for it, so no clock stretching
	assign sif.scl_pin = i_scl;
	assign sif.osc_en = i_osc_en;
	assign sif.start_tgl = start_tgl_q;

	stall_watchdog #(
		.STALL_CYCLES(STALL_CYCLES)
	) u_watchdog (
		.i_osc_clk(i_osc_clk),
		.i_rst(i_rst),
		.sif(sif)
	);

	// pins and the stall toggle pass two stages before use
	always_ff @(posedge i_mclk) begin
		scl_s1_q <= i_scl;
		scl_s2_q <= scl_s1_q;
		scl_p_q <= scl_s2_q;
		sda_s1_q <= i_sda;
		sda_s2_q <= sda_s1_q;
		sda_p_q <= sda_s2_q;
		stl_s1_q <= sif.stall_tgl;
		stl_s2_q <= stl_s1_q;
		stl_s3_q <= stl_s2_q;
	end

	// bus events from synchronised levels
	assign scl_rise = scl_s2_q && !scl_p_q;
	assign scl_fall = !scl_s2_q && scl_p_q;
	assign start_ev = scl_s2_q && scl_p_q && !sda_s2_q && sda_p_q;
	assign stop_ev = scl_s2_q && scl_p_q && sda_s2_q && !sda_p_q;
	assign stall_ev = stl_s2_q ^ stl_s3_q;

	// start restarts the watchdog as well
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			start_tgl_q <= 1'b0;
		end else if (start_ev) begin
			start_tgl_q <= ~start_tgl_q;
		end
	end

	// receive side sampling on rising scl
	always_ff @(posedge i_mclk) begin
		if (i_rst || start_ev) begin
			bit_q <= '0;
			shift_q <= '0;
			ack_q <= 1'b0;
		end else if (scl_fall && (state_q == ST_ADDR_ACK || state_q == ST_WR_ACK || state_q == ST_RD_ACK)) begin
			bit_q <= '0;
		end else if (scl_rise) begin
			shift_q <= {shift_q[6:0], sda_s2_q};
			if (state_q == ST_RD_ACK) begin
				ack_q <= !sda_s2_q;
			end else if (bit_q != 4'h8) begin
				bit_q <= bit_q + 1'b1;
			end
		end
	end

	// sequencing; stall recovery beats everything, start beats stop and edges
	always_ff @(posedge i_mclk) begin
		if (i_rst || stall_ev) begin
			state_q <= ST_IDLE;
			sda_oe_q <= 1'b0;
			first_q <= 1'b0;
			rw_q <= 1'b0;
			tx_q <= '0;
		end else if (start_ev) begin
			state_q <= ST_ADDR;
			sda_oe_q <= 1'b0;
			first_q <= 1'b1;
		end else if (stop_ev) begin
			state_q <= ST_IDLE;
			sda_oe_q <= 1'b0;
		end else if (scl_fall) begin
			case (state_q)
				ST_ADDR: begin
					if (bit_q == 4'h8) begin
						if (shift_q[7:1] == `SLAVE_ADDR) begin
							state_q <= ST_ADDR_ACK;
							rw_q <= shift_q[0];
							sda_oe_q <= 1'b1;
						end else begin
							state_q <= ST_IGNORE;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (rw_q == `DIR_READ) begin
						state_q <= ST_RD_BYTE;
						tx_q <= i_reg_rdata;
						sda_oe_q <= !i_reg_rdata[7];
					end else begin
						state_q <= ST_WR_BYTE;
						sda_oe_q <= 1'b0;
					end
				end
				ST_WR_BYTE: begin
					if (bit_q == 4'h8) begin
						state_q <= ST_WR_ACK;
						sda_oe_q <= 1'b1;
					end
				end
				ST_WR_ACK: begin
					state_q <= ST_WR_BYTE;
					sda_oe_q <= 1'b0;
					first_q <= 1'b0;
				end
				ST_RD_BYTE: begin
					if (bit_q == 4'h8) begin
						state_q <= ST_RD_ACK;
						sda_oe_q <= 1'b0;
					end else begin
						tx_q <= {tx_q[6:0], 1'b0};
						sda_oe_q <= !tx_q[6];
					end
				end
				ST_RD_ACK: begin
					if (ack_q) begin
						state_q <= ST_RD_BYTE;
						tx_q <= i_reg_rdata;
						sda_oe_q <= !i_reg_rdata[7];
					end else begin
						state_q <= ST_IGNORE;
						sda_oe_q <= 1'b0;
					end
				end
				ST_IDLE, ST_IGNORE: begin
					sda_oe_q <= 1'b0;
				end
				default: begin
					state_q <= ST_IDLE;
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	// register pointer: loaded by the first write byte, bumped after every data byte
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ptr_q <= '0;
			wr_en_q <= 1'b0;
			wr_data_q <= '0;
		end else begin
			wr_en_q <= 1'b0;
			if (scl_fall && !start_ev && !stop_ev && !stall_ev && bit_q == 4'h8) begin
				if (state_q == ST_WR_BYTE && first_q) begin
					ptr_q <= shift_q;
				end else if (state_q == ST_WR_BYTE) begin
					wr_en_q <= 1'b1;
					wr_data_q <= shift_q;
					ptr_q <= ptr_q + 1'b1;
				end else if (state_q == ST_RD_BYTE) begin
					ptr_q <= ptr_q + 1'b1;
				end
			end
		end
	end

	// shared pin is open drain: the data output is tied low, only the enable flop moves
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			irq_oe_q <= 1'b0;
		end else begin
			irq_oe_q <= i_irq_a_req;
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe = sda_oe_q;
	assign o_refclk_in_irq_a_pin_out = 1'b0;
	assign o_refclk_in_irq_a_pin_oe = irq_oe_q;
	assign o_reg_addr = ptr_q;
	assign o_wr_en = wr_en_q;
	assign o_wr_data = wr_data_q;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	sequence s_nack_end;
		state_q == ST_RD_ACK && scl_fall && !ack_q && !start_ev && !stop_ev && !stall_ev;
	endsequence
	sequence s_ack_more;
		state_q == ST_RD_ACK && scl_fall && ack_q && !start_ev && !stop_ev && !stall_ev;
	endsequence
	sequence s_byte_sent;
		state_q == ST_RD_BYTE && scl_fall && bit_q == 4'h8 && !start_ev && !stop_ev && !stall_ev;
	endsequence

	a_nack_releases: assert property (s_nack_end |=> !sda_oe_q [*2])
		else $error("sda still driven after master nack");
	a_ack_next_byte: assert property (s_ack_more |=> state_q == ST_RD_BYTE && sda_oe_q == !$past(i_reg_rdata[7]))
		else $error("no next byte after master ack");
	a_ptr_advance: assert property (s_byte_sent |=> o_reg_addr == $past(o_reg_addr) + 8'h01)
		else $error("pointer not advanced after read byte");
	a_stall_recovery: assert property (stall_ev |=> state_q == ST_IDLE && !o_sda_oe)
		else $error("stall did not reset the interface");
	a_ignore_quiet: assert property (state_q == ST_IGNORE && !start_ev |=> !o_sda_oe)
		else $error("sda driven while ignoring");
	a_addr_mismatch: assert property (state_q == ST_ADDR && scl_fall && bit_q == 4'h8 && !start_ev && !stop_ev
		&& !stall_ev && shift_q[7:1] != `SLAVE_ADDR |=> state_q == ST_IGNORE)
		else $error("foreign address answered");
	a_ptr_load: assert property (state_q == ST_WR_BYTE && first_q && scl_fall && bit_q == 4'h8 && !start_ev
		&& !stop_ev && !stall_ev |=> o_reg_addr == $past(shift_q) && !o_wr_en)
		else $error("pointer not loaded from first write byte");
	a_read_from_ptr: assert property (state_q == ST_ADDR_ACK && rw_q && scl_fall && !start_ev && !stop_ev
		&& !stall_ev |=> tx_q == $past(i_reg_rdata))
		else $error("read did not start at pointer");
	// the enable must track the request too, else a stuck enable would pass unseen
	a_open_drain_pins: assert property (o_sda_out == 1'b0 && o_refclk_in_irq_a_pin_out == 1'b0
		&& o_refclk_in_irq_a_pin_oe == $past(i_irq_a_req))
		else $error("open drain pin driven high");
endmodule : rtc_i2c_read_and_bus_timeout

`default_nettype wire

// file: rtl/rtc_i2c_defs.svh
`ifndef RTC_I2C_DEFS_SVH
`define RTC_I2C_DEFS_SVH

// fixed bus address, upper seven bits of the address byte
`define SLAVE_ADDR 7'h68
// direction bit values in the address byte
`define DIR_WRITE 1'h0
`define DIR_READ 1'h1
// scl-low stall limits in microseconds
`define STALL_MIN_US 32'h0000_61A8
`define STALL_MAX_US 32'h0000_88B8
// oscillator rate that times the stall, in hertz
`define OSC_HZ 32'h0000_8000
// stall limit in oscillator cycles, from the longest time, rounded up
`define STALL_CYCLES ((`STALL_MAX_US * `OSC_HZ + 32'h000F_423F) / 32'h000F_4240)

`endif

// file: rtl/rtc_i2c_pkg.sv
package rtc_i2c_pkg;

	// serial slave sequencing
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR_BYTE,
		ST_WR_ACK,
		ST_RD_BYTE,
		ST_RD_ACK,
		ST_IGNORE
	} slave_state_type;

endpackage : rtc_i2c_pkg

// file: rtl/stall_if.sv
`timescale 1ns/1ps
`default_nettype none

// carries the stall watchdog handshakes between the two clock domains
interface stall_if;
	logic scl_pin;
	logic osc_en;
	logic start_tgl;
	logic stall_tgl;

	modport watchdog (
		input scl_pin,
		input osc_en,
		input start_tgl,
		output stall_tgl
	);
	modport slave (
		output scl_pin,
		output osc_en,
		output start_tgl,
		input stall_tgl
	);
endinterface : stall_if

`default_nettype wire

// file: rtl/stall_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

`include "rtc_i2c_defs.svh"

module stall_watchdog #(
	parameter int STALL_CYCLES = `STALL_CYCLES,
	parameter int CNT_W = $clog2(STALL_CYCLES + 1)
) (
	input wire logic i_osc_clk,
	input wire logic i_rst,
	stall_if.watchdog sif
);
	logic rst_s1_q, rst_s2_q;
	logic scl_s1_q, scl_s2_q;
	logic en_s1_q, en_s2_q;
	logic st_s1_q, st_s2_q, st_s3_q;
	logic [CNT_W-1:0] cnt_q;
	logic stall_tgl_q;
	logic start_seen;

	// every input here is foreign to the oscillator, so two stages each
	always_ff @(posedge i_osc_clk) begin
		rst_s1_q <= i_rst;
		rst_s2_q <= rst_s1_q;
		scl_s1_q <= sif.scl_pin;
		scl_s2_q <= scl_s1_q;
		en_s1_q <= sif.osc_en;
		en_s2_q <= en_s1_q;
		st_s1_q <= sif.start_tgl;
		st_s2_q <= st_s1_q;
		st_s3_q <= st_s2_q;
	end

	assign start_seen = st_s2_q ^ st_s3_q;

	// count only while scl is low and the oscillator runs; saturates so one stall fires once
	always_ff @(posedge i_osc_clk) begin
		if (rst_s2_q || !en_s2_q || scl_s2_q || start_seen) begin
			cnt_q <= '0;
		end else if (cnt_q != CNT_W'(STALL_CYCLES)) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// event to the bus clock as a toggle, a pulse could be missed there
	always_ff @(posedge i_osc_clk) begin
		if (rst_s2_q) begin
			stall_tgl_q <= 1'b0;
		end else if (en_s2_q && !scl_s2_q && !start_seen && cnt_q == CNT_W'(STALL_CYCLES - 1)) begin
			stall_tgl_q <= ~stall_tgl_q;
		end
	end

	assign sif.stall_tgl = stall_tgl_q;

	default clocking cb @(posedge i_osc_clk); endclocking
	default disable iff (rst_s2_q);

	a_osc_stopped_idle: assert property (!en_s2_q |=> cnt_q == '0 && $stable(stall_tgl_q))
		else $error("stall counted with oscillator stopped");
	a_scl_high_restart: assert property (scl_s2_q && !$past(rst_s2_q) |=> cnt_q == '0)
		else $error("stall count not restarted by scl high");
	a_stall_fires: assert property (cnt_q != CNT_W'(STALL_CYCLES) ##1 cnt_q == CNT_W'(STALL_CYCLES)
		|-> stall_tgl_q != $past(stall_tgl_q))
		else $error("stall limit reached without event");
endmodule : stall_watchdog

`default_nettype wire

// file: tb/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// far-side bus master; scl is driven push-pull, which works only because the slave never stretches
module i2c_master_model (
	input wire logic i_mclk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	// idle bus: scl high, data left to its pull-up
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
	endtask : tick

	// start or repeated start: data falls while scl is high
	task automatic start_cond();
		o_sda_low <= 1'b0;
		tick(4);
		o_scl <= 1'b1;
		tick(4);
		o_sda_low <= 1'b1;
		tick(4);
		o_scl <= 1'b0;
	endtask : start_cond

	// stop closes the last transfer of each test, also after the nack of the last read byte
	task automatic stop_cond();
		tick(4);
		o_sda_low <= 1'b1;
		tick(4);
		o_scl <= 1'b1;
		tick(4);
		o_sda_low <= 1'b0;
		tick(8);
	endtask : stop_cond

	// one bit; low phase kept at 8 cycles, far under the stall limit
	task automatic bit_xfer(input logic b, output logic r);
		tick(4);
		o_sda_low <= !b;
		tick(4);
		o_scl <= 1'b1;
		tick(4);
		r = i_sda;
		tick(4);
		o_scl <= 1'b0;
	endtask : bit_xfer

	// nine bits msb first; bit 0 is the acknowledge slot, 0 asks for more
	task automatic frame(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			bit_xfer(tx[i], rx[i]);
		end
	endtask : frame
endmodule : i2c_master_model

`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic i_mclk, i_osc_clk, i_rst, i_osc_en, i_irq_a_req;
	logic [7:0] reg_rdata;
	logic scl, sda_low, sda, sda_oe, sda_out, pin_out, pin_oe, wr_en;
	logic [7:0] reg_addr, wr_data, wr_seen;
	logic [8:0] rx;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;

	always #12.5 i_mclk = ~i_mclk;
	always #16 i_osc_clk = ~i_osc_clk;

	// open-drain data wire with its pull-up
	assign sda = (sda_oe || sda_low) ? 1'b0 : 1'b1;

	// register file stand-in: each location reads as its address with a fixed pattern
	assign reg_rdata = reg_addr ^ 8'hA5;

	rtc_i2c_read_and_bus_timeout #(.STALL_CYCLES(20)) i_dut (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_osc_clk(i_osc_clk), .i_osc_en(i_osc_en),
		.i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.i_irq_a_req(i_irq_a_req), .o_refclk_in_irq_a_pin_out(pin_out),
		.o_refclk_in_irq_a_pin_oe(pin_oe), .o_reg_addr(reg_addr),
		.i_reg_rdata(reg_rdata), .o_wr_en(wr_en), .o_wr_data(wr_data)
	);

	i2c_master_model i_mst (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

	// keep the last written byte; the strobe lasts one cycle only
	always @(posedge i_mclk) begin
		if (wr_en === 1'b1) wr_seen <= wr_data;
	end

	task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : stop_test

	// hang guard, far above the fewer than two thousand cycles the tests need
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			stop_test();
		end
	end

	// pointer write, one data write that carries the pointer to 8'h10, then two reads
	task automatic test_write_read();
		i_mst.start_cond();
		i_mst.frame({8'hD0, 1'b1}, rx);
		check(rx[0], 1'b0, "write addr ack");
		i_mst.frame({8'h0F, 1'b1}, rx);
		i_mst.frame({8'h3C, 1'b1}, rx);
		i_mst.tick(4);
		check(wr_seen, 8'h3C, "written byte");
		check(reg_addr, 8'h10, "pointer after write");
		i_mst.start_cond();
		i_mst.frame({8'hD1, 1'b1}, rx);
		i_mst.frame({8'hFF, 1'b0}, rx);
		check(rx[8:1], 8'h10 ^ 8'hA5, "first read");
		i_mst.frame({8'hFF, 1'b1}, rx);
		check(rx[8:1], 8'h11 ^ 8'hA5, "second read");
		i_mst.tick(6);
		check(sda_oe, 1'b0, "release after nack");
		i_mst.stop_cond();
		$display("done: write then read");
	endtask : test_write_read

	// a foreign address is never acknowledged nor answered
	task automatic test_wrong_addr();
		i_mst.start_cond();
		i_mst.frame({8'hA1, 1'b1}, rx);
		check(rx, 9'h143, "foreign addr");
		i_mst.frame({8'hFF, 1'b1}, rx);
		check(rx, 9'h1FF, "ignored byte");
		i_mst.stop_cond();
		$display("done: wrong address");
	endtask : test_wrong_addr

	// scl stuck low during the ack; first with the oscillator off, then on
	task automatic test_stall();
		logic [7:0] a;
		logic r;
		a = 8'hD1;
		i_mst.start_cond();
		for (int i = 7; i >= 0; i--) i_mst.bit_xfer(a[i], r);
		i_mst.tick(8);
		check(sda_oe, 1'b1, "ack held");
		i_osc_en <= 1'b0;
		i_mst.tick(150);
		check(sda_oe, 1'b1, "no recovery, osc off");
		i_osc_en <= 1'b1;
		i_mst.tick(60);
		check(sda_oe, 1'b0, "stall release");
		i_mst.start_cond();
		i_mst.frame({8'hD1, 1'b1}, rx);
		check(rx[0], 1'b0, "ack after recovery");
		i_mst.frame({8'hFF, 1'b1}, rx);
		check(rx[8:1], 8'h12 ^ 8'hA5, "read after recovery");
		i_mst.stop_cond();
		$display("done: stall");
	endtask : test_stall

	// shared pin and data pin are only ever pulled low
	task automatic test_pins();
		i_irq_a_req <= 1'b1;
		i_mst.tick(3);
		check(pin_oe, 1'b1, "irq pin pulled");
		check(pin_out, 1'b0, "irq pin level");
		check(sda_out, 1'b0, "sda level");
		i_irq_a_req <= 1'b0;
		i_mst.tick(3);
		check(pin_oe, 1'b0, "irq pin released");
		$display("done: pins");
	endtask : test_pins

	initial begin
		i_mclk = 1'b0;
		i_osc_clk = 1'b0;
		i_rst = 1'b1;
		i_osc_en = 1'b1;
		i_irq_a_req = 1'b0;
		repeat (20) @(posedge i_mclk);
		i_rst <= 1'b0;
		i_mst.tick(8);
		test_write_read();
		test_wrong_addr();
		test_stall();
		test_pins();
		stop_test();
	end
endmodule : tb_top

`default_nettype wire
